// ==== design/bit_sync.sv ====
/*
  Two-flop synchroniser for a group of independent levels.
  Assumes each bit is a quasi-static level from outside the clock domain.
*/
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock_i,           // System clock
  input wire logic rst_b_i,           // Async reset, active low
  input wire logic [WIDTH-1:0] d_i,   // Asynchronous levels
  output logic [WIDTH-1:0] q_o        // Synchronised levels
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // ==========================================================
  // Two stages; only the second stage is visible
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;
endmodule

// ==== design/expander_pkg.sv ====
/*
  Shared constants for the eight-bit bus-controlled port expander.
  Assumes a single 200 MHz clock and an active-low asynchronous reset.
*/
package expander_pkg;
  // ==========================================================
  // Widths
  localparam int PIN_COUNT = 8;
  localparam int BIT_CNT_W = 4;
  // ==========================================================
  // Bus address and byte framing
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h70;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // ==========================================================
  // Command codes
  localparam logic [1:0] CMD_INPUT = 2'h0;
  localparam logic [1:0] CMD_OUTPUT = 2'h1;
  localparam logic [1:0] CMD_POLARITY = 2'h2;
  localparam logic [1:0] CMD_CONFIG = 2'h3;
  // ==========================================================
  // Reset values
  localparam logic [7:0] OUTPUT_RESET = 8'hff;
  localparam logic [7:0] POLARITY_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'hff;
  localparam logic [1:0] CMD_RESET = 2'h0;
  // ==========================================================
  // Cycles before the input latch is trusted after reset
  localparam logic [1:0] PRIME_CYCLES = 2'h3;
  // ==========================================================
  // Bus state machine
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_CMD      = 4'h3,
    ST_CMD_ACK  = 4'h4,
    ST_WR       = 4'h5,
    ST_WR_ACK   = 4'h6,
    ST_RD       = 4'h7,
    ST_RD_ACK   = 4'h8
  } bus_state_t;
endpackage

// ==== design/io_expander_top.sv ====
/*
  Eight-bit port expander behind a two-wire serial slave with change alert.
  Assumes SCL and SDA are oversampled by clock_i; both are slow against 200 MHz.
  The reset input serves as both power-on and pin reset.
*/
`timescale 1ns/1ps
module io_expander_top (
  input wire logic clock_i,                                    // 200 MHz clock
  input wire logic rst_b_i,                                    // Async reset, active low
  input wire logic scl_i,                                      // Bus clock level
  input wire logic sda_i,                                      // Bus data level
  output logic sda_o,                                          // Bus data drive value
  output logic sda_oe_b_o,                                     // Low while pulling SDA
  input wire logic addr_select_bit0_i,                         // Address bit 0 strap
  input wire logic addr_select_bit1_i,                         // Address bit 1 strap
  input wire logic [expander_pkg::PIN_COUNT-1:0] expander_pins_i,  // Pin levels
  output logic [expander_pkg::PIN_COUNT-1:0] expander_pins_o,      // Pin drive levels
  output logic [expander_pkg::PIN_COUNT-1:0] expander_pins_oe_b_o, // Low while driving
  output logic alert_o,                                        // Alert drive value
  output logic alert_oe_b_o                                    // Low while alert asserted
);
  import expander_pkg::*;

  // ==========================================================
  // Input synchronisers
  logic [3:0] bus_sync;
  logic [PIN_COUNT-1:0] pin_sync;
  logic scl_s;
  logic sda_s;
  logic [6:0] slave_addr;

  bit_sync #(.WIDTH(4)) u_bus_sync (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .d_i({scl_i, sda_i, addr_select_bit1_i, addr_select_bit0_i}),
    .q_o(bus_sync)
  );

  bit_sync #(.WIDTH(PIN_COUNT)) u_pin_sync (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .d_i(expander_pins_i),
    .q_o(pin_sync)
  );

  assign scl_s = bus_sync[3];
  assign sda_s = bus_sync[2];
  assign slave_addr = {SLAVE_ADDR_BASE[6:2], bus_sync[1], bus_sync[0]};

  // ==========================================================
  // Register state
  bus_state_t state_reg, state_next;
  logic [BIT_CNT_W-1:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] tx_reg, tx_next;
  logic sda_drive_reg, sda_drive_next;
  logic rw_reg, rw_next;
  logic nack_reg, nack_next;
  logic scl_q_reg, sda_q_reg;
  logic [1:0] cmd_reg, cmd_next;
  logic [7:0] out_reg, out_next;
  logic [7:0] pol_reg, pol_next;
  logic [7:0] cfg_reg, cfg_next;
  logic [7:0] latch_reg, latch_next;
  logic [1:0] prime_reg, prime_next;
  logic alert_reg, alert_next;
  logic latch_load;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic primed;
  logic [7:0] mismatch;
  logic addr_match;

  // ==========================================================
  // Register selected by the command for a read
  function automatic logic [7:0] read_value(input logic [1:0] cmd, input logic [7:0] pins,
                                            input logic [7:0] pol, input logic [7:0] outr,
                                            input logic [7:0] cfg);
    logic [7:0] v;
    v = 8'h00;
    case (cmd)
      CMD_INPUT: v = pins ^ pol;
      CMD_OUTPUT: v = outr;
      CMD_POLARITY: v = pol;
      CMD_CONFIG: v = cfg;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ==========================================================
  // Bus line events
  assign scl_rise = scl_s && !scl_q_reg;
  assign scl_fall = !scl_s && scl_q_reg;
  // framing on SDA change with SCL high
  assign start_det = scl_s && scl_q_reg && sda_q_reg && !sda_s;
  assign stop_det = scl_s && scl_q_reg && !sda_q_reg && sda_s;
  assign addr_match = (shift_reg[7:1] == slave_addr);

  // ==========================================================
  // Bus state machine and register file
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    sda_drive_next = sda_drive_reg;
    rw_next = rw_reg;
    nack_next = nack_reg;
    cmd_next = cmd_reg;
    out_next = out_reg;
    pol_next = pol_reg;
    cfg_next = cfg_reg;
    latch_load = 1'b0;
    if (start_det)
    begin
      state_next = ST_ADDR;
      cnt_next = '0;
      sda_drive_next = 1'b0;
    end
    else if (stop_det)
    begin
      state_next = ST_IDLE;
      sda_drive_next = 1'b0;
    end
    else
    begin
      if (scl_rise && state_reg != ST_IDLE)
      begin
        shift_next = {shift_reg[6:0], sda_s};
        cnt_next = cnt_reg + 1'b1;
      end
      if (scl_rise && state_reg == ST_RD_ACK)
      begin
        nack_next = sda_s;
        if (cmd_reg == CMD_INPUT)
          latch_load = 1'b1;
      end
      if (scl_fall)
      begin
        case (state_reg)
          ST_ADDR:
          begin
            if (cnt_reg == BITS_PER_BYTE)
            begin
              if (addr_match)
              begin
                state_next = ST_ADDR_ACK;
                sda_drive_next = 1'b1;
                rw_next = shift_reg[0];
              end
              else
                state_next = ST_IDLE;
            end
          end
          ST_ADDR_ACK, ST_RD_ACK:
          begin
            cnt_next = '0;
            if ((state_reg == ST_RD_ACK && nack_reg) || (state_reg == ST_ADDR_ACK && !rw_reg))
            begin
              state_next = (state_reg == ST_RD_ACK) ? ST_IDLE : ST_CMD;
              sda_drive_next = 1'b0;
            end
            else
            begin
              tx_next = read_value(cmd_reg, pin_sync, pol_reg, out_reg, cfg_reg);
              sda_drive_next = !tx_next[7];
              tx_next = {tx_next[6:0], 1'b0};
              state_next = ST_RD;
            end
          end
          ST_CMD:
          begin
            if (cnt_reg == BITS_PER_BYTE)
            begin
              cmd_next = shift_reg[1:0];
              sda_drive_next = 1'b1;
              state_next = ST_CMD_ACK;
            end
          end
          ST_CMD_ACK, ST_WR_ACK:
          begin
            sda_drive_next = 1'b0;
            cnt_next = '0;
            state_next = ST_WR;
          end
          ST_WR:
          begin
            if (cnt_reg == BITS_PER_BYTE)
            begin
              case (cmd_reg)
                CMD_OUTPUT: out_next = shift_reg;
                CMD_POLARITY: pol_next = shift_reg;
                CMD_CONFIG: cfg_next = shift_reg;
                default: out_next = out_reg;
              endcase
              sda_drive_next = 1'b1;
              state_next = ST_WR_ACK;
            end
          end
          ST_RD:
          begin
            if (cnt_reg == BITS_PER_BYTE)
            begin
              sda_drive_next = 1'b0;
              state_next = ST_RD_ACK;
            end
            else
            begin
              sda_drive_next = !tx_reg[7];
              tx_next = {tx_reg[6:0], 1'b0};
            end
          end
          default: state_next = state_reg;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      sda_drive_reg <= 1'b0;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      // Match the synchroniser reset level so no false edge follows reset
      scl_q_reg <= 1'b0;
      sda_q_reg <= 1'b0;
      cmd_reg <= CMD_RESET;
      out_reg <= OUTPUT_RESET;
      pol_reg <= POLARITY_RESET;
      cfg_reg <= CONFIG_RESET;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      sda_drive_reg <= sda_drive_next;
      rw_reg <= rw_next;
      nack_reg <= nack_next;
      scl_q_reg <= scl_s;
      sda_q_reg <= sda_s;
      cmd_reg <= cmd_next;
      out_reg <= out_next;
      pol_reg <= pol_next;
      cfg_reg <= cfg_next;
    end
  end

  // ==========================================================
  // Change alert
  assign primed = (prime_reg == PRIME_CYCLES);
  assign mismatch = (pin_sync ^ latch_reg) & cfg_reg;

  always_comb
  begin
    prime_next = primed ? prime_reg : prime_reg + 1'b1;
    latch_next = latch_reg;
    if (!primed || latch_load)
      latch_next = pin_sync;
    alert_next = primed && (|mismatch);
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      prime_reg <= 2'h0;
      latch_reg <= 8'h00;
      alert_reg <= 1'b0;
    end
    else
    begin
      prime_reg <= prime_next;
      latch_reg <= latch_next;
      alert_reg <= alert_next;
    end
  end

  // ==========================================================
  // Pin outputs
  port_driver u_port_driver (
    .dir_in_i(cfg_reg),
    .level_i(out_reg),
    .pin_o(expander_pins_o),
    .pin_oe_b_o(expander_pins_oe_b_o)
  );

  assign sda_o = 1'b0;
  assign sda_oe_b_o = !sda_drive_reg;
  assign alert_o = 1'b0;
  assign alert_oe_b_o = !alert_reg;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  a_pin_drive_dir: assert property ((expander_pins_oe_b_o == cfg_reg) &&
    ((expander_pins_o & ~cfg_reg) == (out_reg & ~cfg_reg)))
    else $error("pin drive does not follow direction and output registers");

  a_alert_raise: assert property ((primed && (|mismatch)) |=> !alert_oe_b_o)
    else $error("alert not asserted on input mismatch");

  a_alert_release: assert property (!(|mismatch) |=> alert_oe_b_o)
    else $error("alert asserted with no input mismatch");

  a_read_clear: assert property ((state_reg == ST_RD_ACK && scl_rise && cmd_reg == CMD_INPUT
    && !start_det && !stop_det && primed) |=> (latch_reg == $past(pin_sync)))
    else $error("input latch not refreshed at read acknowledge");

  a_foreign_ignore: assert property ((state_reg == ST_ADDR && scl_fall && cnt_reg == BITS_PER_BYTE
    && !addr_match && !start_det && !stop_det) |=> (state_reg == ST_IDLE) && sda_oe_b_o)
    else $error("foreign address not ignored");

  a_addr_ack: assert property ((state_reg == ST_ADDR && scl_fall && cnt_reg == BITS_PER_BYTE
    && addr_match && !start_det && !stop_det) |=> !sda_oe_b_o ##0 (sda_oe_b_o == 1'b0) [*1])
    else $error("own address not acknowledged");

  a_cmd_hold: assert property ($changed(cmd_reg) |-> $past(state_reg) == ST_CMD)
    else $error("command changed outside command byte");

  a_nack_release: assert property ((state_reg == ST_RD_ACK && scl_fall && nack_reg
    && !start_det && !stop_det) |=> sda_oe_b_o && (state_reg == ST_IDLE))
    else $error("SDA not released after master NACK");

  a_stop_idle: assert property (stop_det |=> (state_reg == ST_IDLE) && sda_oe_b_o)
    else $error("stop did not return bus to idle");

  c_addr_ack: cover property (state_reg == ST_ADDR_ACK ##1 state_reg == ST_CMD);
  c_write_byte: cover property (state_reg == ST_WR ##1 state_reg == ST_WR_ACK);
  c_read_clear: cover property (!alert_oe_b_o ##[1:1000] latch_load ##2 alert_oe_b_o);
  c_read_nack: cover property (state_reg == ST_RD_ACK && nack_reg ##1 state_reg == ST_IDLE);
endmodule

// ==== design/port_driver.sv ====
/*
  Per-pin driver control for the expander port.
  Assumes direction and output values come from registers.
*/
`timescale 1ns/1ps
module port_driver (
  input wire logic [expander_pkg::PIN_COUNT-1:0] dir_in_i,  // 1 = pin is input
  input wire logic [expander_pkg::PIN_COUNT-1:0] level_i,   // Output register
  output logic [expander_pkg::PIN_COUNT-1:0] pin_o,         // Driven level
  output logic [expander_pkg::PIN_COUNT-1:0] pin_oe_b_o     // Low while driving
);
  import expander_pkg::*;

  // ==========================================================
  // Input pins have both drivers off; outputs drive high or low
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g = g + 1)
    begin : g_pin
      assign pin_oe_b_o[g] = dir_in_i[g];
      assign pin_o[g] = level_i[g];
    end
  endgenerate
endmodule

// ==== tb/bus_master_model.sv ====
/*
  Two-wire bus master model that frames transfers toward the expander.
  Assumes the bench resolves SDA with a pull-up and returns it on sda_i.
*/
`timescale 1ns/1ps
module bus_master_model #(
  parameter int QUARTER = 8
) (
  input wire logic clock_i,  // System clock
  input wire logic sda_i,    // Resolved SDA level
  output logic scl_o,        // SCL level, idles high
  output logic sda_o         // SDA drive, 1 releases the line
);
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic pause(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // ==========================================================
  // Framing
  // start and repeated start
  task automatic start_cond();
    pause(QUARTER);
    sda_o <= 1'b1;
    pause(QUARTER);
    scl_o <= 1'b1;
    pause(QUARTER);
    sda_o <= 1'b0;
    pause(QUARTER);
    scl_o <= 1'b0;
  endtask

  task automatic stop_cond();
    pause(QUARTER);
    sda_o <= 1'b0;
    pause(QUARTER);
    scl_o <= 1'b1;
    pause(QUARTER);
    sda_o <= 1'b1;
    pause(QUARTER);
  endtask

  // ==========================================================
  // Bits and bytes
  // SDA moves only while SCL low
  task automatic xfer_bit(input logic b, output logic r);
    pause(QUARTER);
    sda_o <= b;
    pause(QUARTER);
    scl_o <= 1'b1;
    pause(QUARTER);
    r = sda_i;
    pause(QUARTER);
    scl_o <= 1'b0;
  endtask

  // MSB first, SDA released for acknowledge
  task automatic write_byte(input logic [7:0] d, output logic acked);
    logic r;
    for (int i = 7; i >= 0; i--)
      xfer_bit(d[i], r);
    xfer_bit(1'b1, r);
    acked = ~r;
  endtask

  // acknowledge all but the last byte
  task automatic read_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      xfer_bit(1'b1, d[i]);
    xfer_bit(last, r);
  endtask
endmodule

// ==== tb/tb.sv ====
/*
  Self-checking bench for the port expander, driving the bus through a master model.
  Assumes the design answers on the bus within a few clocks of each SCL edge.
*/
`timescale 1ns/1ps
module tb;
  import expander_pkg::*;
  logic clock, rst_b, scl, sda_m, sda, sda_drv, sda_oe_b, a0, a1, alert, alert_oe_b;
  logic [PIN_COUNT-1:0] ext, pins_in, pins_out, pins_oe_b;
  logic [6:0] dev_adr;
  logic [7:0] b0, b1;
  int fail_count, num_checks;

  // Open-drain SDA with pull-up; port pins follow their driver when enabled
  assign sda = sda_m & (sda_oe_b | sda_drv);
  assign pins_in = (pins_oe_b & ext) | (~pins_oe_b & pins_out);

  always #2.5 clock = ~clock;

  io_expander_top i_io_expander_top (
    .clock_i(clock), .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_drv),
    .sda_oe_b_o(sda_oe_b), .addr_select_bit0_i(a0), .addr_select_bit1_i(a1),
    .expander_pins_i(pins_in), .expander_pins_o(pins_out), .expander_pins_oe_b_o(pins_oe_b),
    .alert_o(alert), .alert_oe_b_o(alert_oe_b)
  );

  bus_master_model i_bus_master_model (.clock_i(clock), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));

  // ==========================================================
  // Checking and closing
  task automatic end_sim();
    if (fail_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_alert(input logic exp);
    int n;
    n = 0;
    while (alert_oe_b !== exp && n < 12)
    begin
      @(posedge clock);
      n++;
    end
    check({7'h00, alert_oe_b}, {7'h00, exp});
    if (alert_oe_b !== exp)
      end_sim();
  endtask

  // ==========================================================
  // Bus transfers
  task automatic wr_reg(input logic [6:0] adr, input logic [7:0] cmd, input logic [7:0] d, input logic exp_ack);
    logic ack;
    i_bus_master_model.start_cond();
    i_bus_master_model.write_byte({adr, 1'b0}, ack);
    check({7'h00, ack}, {7'h00, exp_ack});
    if (ack)
    begin
      i_bus_master_model.write_byte(cmd, ack);
      check({7'h00, ack}, 8'h01);
      i_bus_master_model.write_byte(d, ack);
      check({7'h00, ack}, 8'h01);
    end
    i_bus_master_model.stop_cond();
  endtask

  task automatic rd_reg(input logic set_cmd, input logic [7:0] cmd);
    logic ack;
    if (set_cmd)
    begin
      i_bus_master_model.start_cond();
      i_bus_master_model.write_byte({dev_adr, 1'b0}, ack);
      i_bus_master_model.write_byte(cmd, ack);
    end
    i_bus_master_model.start_cond();
    i_bus_master_model.write_byte({dev_adr, 1'b1}, ack);
    check({7'h00, ack}, 8'h01);
    i_bus_master_model.read_byte(1'b0, b0);
    i_bus_master_model.read_byte(1'b1, b1);
    i_bus_master_model.stop_cond();
    check({7'h00, sda_oe_b}, 8'h01);
  endtask

  // ==========================================================
  // Scenarios
  task automatic sc_defaults();
    check(pins_oe_b, 8'hff);
    check(pins_out, 8'hff);
    check({7'h00, alert_oe_b}, 8'h01);
    rd_reg(1'b1, {6'h00, CMD_OUTPUT});
    check(b0, 8'hff);
    rd_reg(1'b1, {6'h00, CMD_POLARITY});
    check(b0, 8'h00);
    rd_reg(1'b1, {6'h00, CMD_CONFIG});
    check(b0, 8'hff);
  endtask

  task automatic sc_alert();
    @(posedge clock);
    ext <= 8'h08;
    wait_alert(1'b0);
    check({7'h00, alert}, 8'h00);
    @(posedge clock);
    ext <= 8'h00;
    wait_alert(1'b1);
    @(posedge clock);
    ext <= 8'h20;
    wait_alert(1'b0);
    wr_reg(dev_adr ^ 7'h02, 8'h00, 8'h00, 1'b0);
    check({7'h00, alert_oe_b}, 8'h00);
    rd_reg(1'b1, {6'h00, CMD_INPUT});
    check(b0, 8'h20);
    check({7'h00, alert_oe_b}, 8'h01);
    @(posedge clock);
    ext <= 8'h00;
    wait_alert(1'b0);
    rd_reg(1'b0, 8'h00);
    check(b1, 8'h00);
    wait_alert(1'b1);
    wr_reg(dev_adr, {6'h00, CMD_CONFIG}, 8'hfe, 1'b1);
    wr_reg(dev_adr, {6'h00, CMD_OUTPUT}, 8'hfe, 1'b1);
    check({7'h00, alert_oe_b}, 8'h01);
  endtask

  task automatic sc_registers();
    logic [7:0] exp [1:3];
    exp[1] = 8'h5a;
    exp[2] = 8'hc3;
    exp[3] = 8'h0f;
    @(posedge clock);
    ext <= 8'h96;
    for (int c = 1; c <= 3; c++)
      wr_reg(dev_adr, 8'(c), exp[c], 1'b1);
    check(pins_out, 8'h5a);
    check(pins_oe_b, 8'h0f);
    for (int c = 1; c <= 3; c++)
    begin
      rd_reg(1'b1, 8'(c));
      check(b0, exp[c]);
      check(b1, exp[c]);
    end
    rd_reg(1'b0, 8'h00);
    check(b0, 8'h0f);
    wr_reg(dev_adr ^ 7'h01, {6'h00, CMD_OUTPUT}, 8'h00, 1'b0);
    check(pins_out, 8'h5a);
    wr_reg(dev_adr, {6'h00, CMD_INPUT}, 8'h00, 1'b1);
    check(pins_out, 8'h5a);
    check(pins_oe_b, 8'h0f);
    rd_reg(1'b1, {6'h00, CMD_INPUT});
    check(b0, ((8'h96 & 8'h0f) | (8'h5a & 8'hf0)) ^ 8'hc3);
  endtask

  task automatic sc_address();
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clock);
      {a1, a0} <= 2'(s);
      i_bus_master_model.pause(6);
      dev_adr = SLAVE_ADDR_BASE | 7'(s);
      wr_reg(dev_adr, {6'h00, CMD_POLARITY}, 8'(s), 1'b1);
      wr_reg(dev_adr ^ 7'h01, {6'h00, CMD_POLARITY}, 8'hff, 1'b0);
      rd_reg(1'b1, {6'h00, CMD_POLARITY});
      check(b0, 8'(s));
    end
  endtask

  task automatic sc_reset_mid();
    logic ack;
    i_bus_master_model.start_cond();
    i_bus_master_model.write_byte({dev_adr, 1'b0}, ack);
    // reset held well past its minimum width
    @(posedge clock);
    rst_b <= 1'b0;
    i_bus_master_model.pause(8);
    check(pins_oe_b, 8'hff);
    check({7'h00, sda_oe_b}, 8'h01);
    rst_b <= 1'b1;
    i_bus_master_model.stop_cond();
    sc_defaults();
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    clock = 1'b0;
    rst_b = 1'b0;
    ext = 8'h00;
    a0 = 1'b0;
    a1 = 1'b0;
    dev_adr = SLAVE_ADDR_BASE;
    fail_count = 0;
    num_checks = 0;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    repeat (10) @(posedge clock);
    sc_defaults();
    sc_alert();
    sc_registers();
    sc_address();
    sc_reset_mid();
    end_sim();
  end
endmodule
